// ### core/gpx_pkg.sv
// Shared constants for the I2C sixteen bit GPIO expander.
package gpx_pkg;

  // Port geometry: two ports of eight pins each.
  localparam int unsigned PORT_W    = 8;
  localparam int unsigned NUM_PORTS = 2;
  localparam int unsigned PIN_W     = PORT_W * NUM_PORTS;
  localparam int unsigned CMD_W     = 3;

  // Register offsets selected by the command byte.
  localparam logic [CMD_W-1:0] OFS_PIN_LEVEL_IN_LO = 3'h0;
  localparam logic [CMD_W-1:0] OFS_PIN_LEVEL_IN_HI = 3'h1;
  localparam logic [CMD_W-1:0] OFS_DRIVE_LATCH_LO  = 3'h2;
  localparam logic [CMD_W-1:0] OFS_DRIVE_LATCH_HI  = 3'h3;
  localparam logic [CMD_W-1:0] OFS_INPUT_INVERT_LO = 3'h4;
  localparam logic [CMD_W-1:0] OFS_INPUT_INVERT_HI = 3'h5;
  localparam logic [CMD_W-1:0] OFS_DIRECTION_LO    = 3'h6;
  localparam logic [CMD_W-1:0] OFS_DIRECTION_HI    = 3'h7;

  // Register groups: bits 2..1 of the command pick the group.
  localparam logic [1:0] GRP_LEVEL  = 2'h0;
  localparam logic [1:0] GRP_LATCH  = 2'h1;
  localparam logic [1:0] GRP_INVERT = 2'h2;
  localparam logic [1:0] GRP_DIR    = 2'h3;

  // Reset values.
  localparam logic [PORT_W-1:0] RST_DRIVE_LATCH = 8'hFF;
  localparam logic [PORT_W-1:0] RST_INVERT      = 8'h00;
  localparam logic [PORT_W-1:0] RST_DIRECTION   = 8'hFF;
  localparam logic [PORT_W-1:0] RST_SENSED      = 8'h00;

  // Default seven bit target address on the I2C bus.
  localparam logic [6:0] DEF_TARGET_ADDR = 7'h20;

  // Bit counter codes.
  localparam logic [3:0] CNT_ARMED = 4'hF;
  localparam logic [3:0] CNT_LAST  = 4'h7;
  localparam logic [3:0] CNT_ACK   = 4'h8;

  // Link phases of one transfer.
  typedef enum logic [2:0] {
    GPX_IDLE,
    GPX_ADDR,
    GPX_CMD,
    GPX_WR,
    GPX_RD,
    GPX_SKIP
  } gpx_state_t;

endpackage

// ### core/gpx_sync.sv
`timescale 1ns/100ps
`default_nettype none

// Three stage synchroniser: the output moves only once stages two and
// three agree, which also rejects a single-cycle glitch.
module gpx_sync #(
  parameter int unsigned     WIDTH = 1,
  parameter logic [WIDTH-1:0] RST  = '0
) (
  input  wire logic             clk_i,   // System clock.
  input  wire logic             reset_i, // Synchronous reset, active high.
  input  wire logic [WIDTH-1:0] async_i, // Level from outside the clock domain.
  output logic      [WIDTH-1:0] sync_o   // Settled level.
);

  if (WIDTH < 1) begin : g_chk
    $error("gpx_sync needs WIDTH of at least one");
  end

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // Stage one feeds stage two only.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      stage1 <= RST;
      stage2 <= RST;
      stage3 <= RST;
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Each bit accepts a change once the two later stages match.
  for (genvar b = 0; b < WIDTH; b++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        sync_o[b] <= RST[b];
      end else if (stage2[b] == stage3[b]) begin
        sync_o[b] <= stage3[b];
      end
    end
  end

endmodule

`default_nettype wire

// ### core/gpx_expander.sv
// Summary of operation
// [RULE1] The first byte after the address in a write transfer is the command pointer.
// [RULE2] Command values 0..7 select input, output, inversion and direction of ports 0 and 1.
// [RULE3] An input register reads the present pin levels whatever the pin direction.
// [RULE4] Writes aimed at the input registers change nothing.
// [RULE5] Input registers have no reset value and follow the pins after reset; the code resets the pin synchroniser to RST_SENSED, 8'h00 per port.
// [RULE6] A latch bit drives its pin only while that pin is an output.
// [RULE7] Reading an output register returns the latch, not the pin level.
// [RULE8] Reset sets every output latch bit to one.
// [RULE9] An inversion bit of one inverts the matching input bit as read.
// [RULE10] Reset clears every inversion bit.
// [RULE11] A direction bit of one makes the pin a released input, zero makes it an output.
// [RULE12] Reset sets every direction bit to one so all pins start as inputs.
// [RULE13] Register bits 7..0 map one to one onto port pins 7..0.
// [RULE14] A read transfer returns the register that the last command selected.
// [RULE15] Only the own target address is acknowledged; other transfers are ignored.
`timescale 1ns/100ps
`default_nettype none

module gpx_expander #(
  parameter logic [6:0] TARGET_ADDR = gpx_pkg::DEF_TARGET_ADDR
) (
  input  wire logic                      clk_i,     // System clock, 125 MHz.
  input  wire logic                      reset_i,   // Synchronous reset, active high.
  input  wire logic                      scl_i,     // I2C serial clock level.
  input  wire logic                      sda_i,     // I2C serial data level.
  output logic                           sda_o,     // Serial data drive value, always low.
  output logic                           sda_oe_o,  // High while pulling serial data low.
  input  wire logic [gpx_pkg::PIN_W-1:0] gpio_i,    // Sensed pin levels.
  output logic      [gpx_pkg::PIN_W-1:0] gpio_o,    // Pin drive values.
  output logic      [gpx_pkg::PIN_W-1:0] gpio_oe_o  // High where a pin is driven.
);
  import gpx_pkg::*;

  if (NUM_PORTS * PORT_W != PIN_W) begin : g_chk
    $error("gpx_expander port geometry is inconsistent");
  end

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  logic             scl_s;
  logic             sda_s;
  logic [PIN_W-1:0] sensed;

  // Bus lines idle high, so they reset high to avoid a false start.
  gpx_sync #(
    .WIDTH (2),
    .RST   (2'h3)
  ) u_bus_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .async_i ({scl_i, sda_i}),
    .sync_o  ({scl_s, sda_s})
  );

  // Pin levels are followed continuously after reset.
  gpx_sync #(
    .WIDTH (PIN_W),
    .RST   ({NUM_PORTS{RST_SENSED}})
  ) u_pin_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .async_i (gpio_i),
    .sync_o  (sensed)
  ); // [RULE5]

  ////////////////////////////////////////////////////////////////////////
  // Bus event detection.

  logic scl_d;
  logic sda_d;

  // Previous settled levels, for edge and condition detection.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Start and stop are data edges while the clock stays high.
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
  wire bus_stop = scl_s & scl_d & ~sda_d & sda_s;

  ////////////////////////////////////////////////////////////////////////
  // Transfer state.

  gpx_state_t       state;
  logic [3:0]       bit_cnt;
  logic [7:0]       shift;
  logic [CMD_W-1:0] ptr;
  logic [7:0]       rd_byte;

  // A byte ends on the falling clock after its eighth bit; the
  // acknowledge slot ends on the following falling clock.
  wire byte_done = scl_fall & (bit_cnt == CNT_LAST);
  wire ack_done = scl_fall & (bit_cnt == CNT_ACK);
  wire addr_hit = (shift[7:1] == TARGET_ADDR);
  wire rd_req = shift[0];
  wire rd_phase = (state == GPX_RD);
  wire rd_load = ack_done & (rd_phase | ((state == GPX_ADDR) & rd_req));
  wire rd_step = scl_fall & rd_phase & (bit_cnt < CNT_LAST);
  wire host_nack = scl_rise & rd_phase & (bit_cnt == CNT_ACK) & sda_s;
  wire rx_phase = (state == GPX_ADDR) | (state == GPX_CMD) | (state == GPX_WR);
  wire rx_bit = scl_rise & rx_phase & (bit_cnt < CNT_ACK);
  wire active = (state != GPX_IDLE) & (state != GPX_SKIP);

  // Acknowledge the own address, the command and every written byte.
  wire ack_now = ((state == GPX_ADDR) & addr_hit) | (state == GPX_CMD)
               | (state == GPX_WR);

  // Phase sequencing; a start always wins, even inside a transfer.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state <= GPX_IDLE;
    end else if (bus_start) begin
      state <= GPX_ADDR;
    end else if (bus_stop) begin
      state <= GPX_IDLE;
    end else if (byte_done & (state == GPX_ADDR) & ~addr_hit) begin
      state <= GPX_SKIP; // [RULE15]
    end else if (host_nack) begin
      state <= GPX_SKIP;
    end else if (ack_done & (state == GPX_ADDR)) begin
      state <= rd_req ? GPX_RD : GPX_CMD; // [RULE1]
    end else if (ack_done & (state == GPX_CMD)) begin
      state <= GPX_WR;
    end
  end

  // The counter is armed one below zero at a start so that the clock
  // fall that closes the start condition is not taken as a bit.
  always_ff @(posedge clk_i) begin
    if (reset_i | bus_stop) begin
      bit_cnt <= 4'h0;
    end else if (bus_start) begin
      bit_cnt <= CNT_ARMED;
    end else if (scl_fall & active) begin
      bit_cnt <= (bit_cnt == CNT_ACK) ? 4'h0 : bit_cnt + 4'h1;
    end
  end

  // Data bits are taken on the rising clock and sent on the falling one.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      shift <= 8'h00;
    end else if (rd_load) begin
      shift <= rd_byte; // [RULE14]
    end else if (rd_step) begin
      shift <= {shift[6:0], 1'b0};
    end else if (rx_bit) begin
      shift <= {shift[6:0], sda_s};
    end
  end

  // The pointer persists across transfers, so a later read returns the
  // register chosen by the last command.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ptr <= OFS_PIN_LEVEL_IN_LO;
    end else if (byte_done & (state == GPX_CMD)) begin
      ptr <= shift[CMD_W-1:0]; // [RULE1] [RULE14]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial data driver.

  // The line is only ever pulled low; a one is sent by releasing it.
  always_ff @(posedge clk_i) begin
    if (reset_i | bus_start | bus_stop) begin
      sda_oe_o <= 1'b0;
    end else if (byte_done) begin
      sda_oe_o <= ack_now & ~rd_phase; // [RULE15]
    end else if (rd_load) begin
      sda_oe_o <= ~rd_byte[7];
    end else if (ack_done) begin
      sda_oe_o <= 1'b0;
    end else if (rd_step) begin
      sda_oe_o <= ~shift[6];
    end
  end

  // Open drain: the drive value is a constant low.
  always_ff @(posedge clk_i) begin
    sda_o <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file.

  logic [PORT_W-1:0] latch  [NUM_PORTS];
  logic [PORT_W-1:0] invert [NUM_PORTS];
  logic [PORT_W-1:0] dir    [NUM_PORTS];
  logic [PORT_W-1:0] view   [2**CMD_W];

  // A data byte is stored when it completes in the write phase.
  wire wr_go = byte_done & (state == GPX_WR);
  wire [1:0] wr_grp = ptr[CMD_W-1:1];

  // Read selection over the eight register views.
  assign rd_byte = view[ptr]; // [RULE2]

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    // Command bit zero selects the port within a group.
    wire sel = (ptr[0] == p[0]);
    wire wr_latch = wr_go & sel & (wr_grp == GRP_LATCH);
    wire wr_invert = wr_go & sel & (wr_grp == GRP_INVERT);
    wire wr_dir = wr_go & sel & (wr_grp == GRP_DIR);
    wire [PORT_W-1:0] next_latch = wr_latch ? shift : latch[p];
    wire [PORT_W-1:0] next_invert = wr_invert ? shift : invert[p];
    wire [PORT_W-1:0] next_dir = wr_dir ? shift : dir[p];
    wire [PORT_W-1:0] pins = sensed[p*PORT_W +: PORT_W];

    // Views; writes to the level group have no decode and are dropped.
    assign view[{GRP_LEVEL, p[0]}] = pins ^ invert[p]; // [RULE3] [RULE4] [RULE9] [RULE13]
    assign view[{GRP_LATCH, p[0]}] = latch[p]; // [RULE7]
    assign view[{GRP_INVERT, p[0]}] = invert[p];
    assign view[{GRP_DIR, p[0]}] = dir[p];

    // Stored configuration with its reset values.
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        latch[p]  <= RST_DRIVE_LATCH; // [RULE8]
        invert[p] <= RST_INVERT; // [RULE10]
        dir[p]    <= RST_DIRECTION; // [RULE12]
      end else begin
        latch[p]  <= next_latch;
        invert[p] <= next_invert;
        dir[p]    <= next_dir;
      end
    end

    // Pin outputs follow the next register values, so a pin changes in
    // the same cycle as the register it reflects.
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        gpio_o[p*PORT_W +: PORT_W]    <= RST_DRIVE_LATCH;
        gpio_oe_o[p*PORT_W +: PORT_W] <= ~RST_DIRECTION;
      end else begin
        gpio_o[p*PORT_W +: PORT_W]    <= next_latch; // [RULE13]
        gpio_oe_o[p*PORT_W +: PORT_W] <= ~next_dir; // [RULE6] [RULE11]
      end
    end
  end

endmodule

`default_nettype wire

// ### core/gpx_expander_note.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ### testbench/gpx_sva.sv
`timescale 1ns/100ps
`default_nettype none
module gpx_sva (
  input wire logic                      clk_i,     // System clock.
  input wire logic                      reset_i,   // Synchronous reset.
  input wire logic                      scl_i,     // Serial clock.
  input wire logic                      sda_i,     // Serial data.
  input wire logic                      sda_o,     // Data drive value.
  input wire logic                      sda_oe_o,  // Data pull enable.
  input wire logic [gpx_pkg::PIN_W-1:0] gpio_i,    // Sensed pins.
  input wire logic [gpx_pkg::PIN_W-1:0] gpio_o,    // Pin drive values.
  input wire logic [gpx_pkg::PIN_W-1:0] gpio_oe_o  // Pin enables.
);
  import gpx_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // An acknowledge or data bit must stand at least the low phase of the bit.
  sequence ack_hold;
    sda_oe_o [*8];
  endsequence
  a_latch_reset:
    assert property ($fell(reset_i) |-> gpio_o == 16'hFFFF) else $error("latch not ones");
  a_dir_reset:
    assert property ($fell(reset_i) |-> gpio_oe_o == 16'h0000) else $error("pins not inputs");
  a_ack_reset:
    assert property ($fell(reset_i) |-> !sda_oe_o) else $error("data held after reset");
  a_sda_zero:
    assert property (sda_o == 1'b0) else $error("data drive value not low");
  a_sda_edge:
    assert property ($changed(sda_oe_o) |-> !scl_i) else $error("data moved with clock high");
  a_ack_holds:
    assert property ($rose(sda_oe_o) |-> ack_hold) else $error("data pull too short");
  a_clk_quiet:
    assert property ($rose(scl_i) |=> $stable(sda_oe_o) [*6]) else $error("data moved in high");
  a_oe_on_ack:
    assert property ($changed(gpio_oe_o) |-> $rose(sda_oe_o)) else $error("direction off ack");
  a_out_on_ack:
    assert property ($changed(gpio_o) |-> $rose(sda_oe_o)) else $error("latch moved off ack");
endmodule
bind gpx_expander gpx_sva chk_u (.clk_i, .reset_i, .scl_i, .sda_i, .sda_o, .sda_oe_o,
  .gpio_i, .gpio_o, .gpio_oe_o);
`default_nettype wire

// ### testbench/gpx_host.sv
`timescale 1ns/100ps
`default_nettype none
// Board host on an open-drain bus: it only ever pulls SDA low.
module gpx_host (
  input  wire logic clk_i,     // System clock.
  input  wire logic sda_i,     // Resolved data wire.
  output logic      scl_o,     // Serial clock, high while idle.
  output logic      sda_low_o  // High pulls data low.
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Data moves mid-low; sampling late in the high phase keeps clear of updates.
  task automatic bt(input logic b, output logic r);
    scl_o <= 1'b0;
    wt(4);
    sda_low_o <= !b;
    wt(4);
    scl_o <= 1'b1;
    wt(6);
    r = sda_i;
    wt(2);
  endtask
  task automatic start();
    sda_low_o <= 1'b1;
    wt(8);
  endtask
  task automatic stop();
    scl_o <= 1'b0;
    wt(4);
    sda_low_o <= 1'b1;
    wt(4);
    scl_o <= 1'b1;
    wt(8);
    sda_low_o <= 1'b0;
    wt(8);
  endtask
  // Byte out, most significant bit first, then the device acknowledge.
  task automatic put(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bt(v[i], r);
    bt(1'b1, r);
    ack = !r;
  endtask
  // Byte in, always closed with a not-acknowledge.
  task automatic get(output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bt(1'b1, r);
      v[i] = r;
    end
    bt(1'b1, r);
  endtask
endmodule
`default_nettype wire

// ### testbench/gpx_expander_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin fails++; \
  $display("FAIL %s exp %h got %h", n, e, s); end end
module gpx_expander_tb;
  import gpx_pkg::*;
  logic        clk_i   = 1'b0;
  logic        reset_i = 1'b1;
  logic [15:0] ext     = 16'hA53C;
  int          fails   = 0;
  int          check_count = 0;
  wire logic        scl, sda_low, sda_oe_o, sda_o, sda;
  wire logic [15:0] gpio_i, gpio_o, gpio_oe_o;
  ////////////////////////////////////////////////////////////////////////////
  // Pull-up on SDA; driven pins show the latch, released ones the outside level.
  assign sda    = !(sda_oe_o | sda_low);
  assign gpio_i = (gpio_oe_o & gpio_o) | (~gpio_oe_o & ext);
  always #4 clk_i = !clk_i;
  gpx_expander dut_u (.clk_i, .reset_i, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe_o,
    .gpio_i, .gpio_o, .gpio_oe_o);
  gpx_host host_u (.clk_i, .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
  ////////////////////////////////////////////////////////////////////////////
  // Command then data in one transfer; a foreign address gets no acknowledge.
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] c, d);
    logic a1, a2, a3;
    host_u.start();
    host_u.put({a, 1'b0}, a1);
    host_u.put(c, a2);
    host_u.put(d, a3);
    host_u.stop();
    `CHK("ack", (a == DEF_TARGET_ADDR) ? 3'b111 : 3'b000, {a1, a2, a3})
  endtask
  task automatic rd_reg(input logic [7:0] c, output logic [7:0] v);
    logic a1, a2, a3;
    host_u.start();
    host_u.put({DEF_TARGET_ADDR, 1'b0}, a1);
    host_u.put(c, a2);
    host_u.stop();
    host_u.start();
    host_u.put({DEF_TARGET_ADDR, 1'b1}, a3);
    host_u.get(v);
    host_u.stop();
    `CHK("rd ack", 3'b111, {a1, a2, a3})
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    logic [7:0] v;
    logic [7:0] rst_v [8] = '{8'h3C, 8'hA5, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF};
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    `CHK("pins", 32'h0000FFFF, {gpio_oe_o, gpio_o})
    for (int r = 0; r < 8; r++) begin
      rd_reg(8'(r), v);
      `CHK("reset", rst_v[r], v)
    end
    wr_reg(DEF_TARGET_ADDR, 8'h02, 8'h5A);
    wr_reg(DEF_TARGET_ADDR, 8'h03, 8'hC3);
    wr_reg(DEF_TARGET_ADDR, 8'h06, 8'h0F);
    wr_reg(DEF_TARGET_ADDR, 8'h07, 8'h00);
    wr_reg(DEF_TARGET_ADDR, 8'h05, 8'h0F);
    `CHK("oe", 16'hFFF0, gpio_oe_o)
    `CHK("out", 16'hC35A, gpio_o)
    rd_reg(8'h00, v);
    `CHK("in lo", 8'h5C, v)
    rd_reg(8'h01, v);
    `CHK("in hi", 8'hCC, v)
    rd_reg(8'h02, v);
    `CHK("latch lo", 8'h5A, v)
    wr_reg(DEF_TARGET_ADDR, 8'h00, 8'h00);
    wr_reg(DEF_TARGET_ADDR, 8'h01, 8'h00);
    rd_reg(8'h00, v);
    `CHK("ro write", 24'h5CC35A, {v, gpio_o})
    wr_reg(DEF_TARGET_ADDR ^ 7'h01, 8'h02, 8'h00);
    rd_reg(8'h02, v);
    `CHK("foreign", 8'h5A, v)
    ext <= 16'h00F0;
    rd_reg(8'h00, v);
    `CHK("in moved", 8'h50, v)
    final_report();
  end
  // Watchdog well beyond the expected run length.
  initial begin
    repeat (60000) @(posedge clk_i);
    fails++;
    final_report();
  end
endmodule
`default_nettype wire
